// file: bstp_regs.vh
// Constants for the boundary-scan test port
// Overview of operation
// - Test-select low gives shared pins test roles and holds the device non-operational.
// - Pins 0..4 carry test clock, mode, data in, data out, test reset.
// - Port follows 2001 boundary-scan; IDCODE BYPASS EXTEST SAMPLE PRELOAD HIGHZ CLAMP.
// - Identification instruction shifts a fixed identification code out of the data path.
`ifndef BSTP_REGS_VH
`define BSTP_REGS_VH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define BSTP_IR_W 4
`define BSTP_IR_CAPTURE 4'h1
`define BSTP_OP_EXTEST 4'h0
`define BSTP_OP_SAMPLE 4'h1
`define BSTP_OP_PRELOAD 4'h2
`define BSTP_OP_IDCODE 4'h3
`define BSTP_OP_HIGHZ 4'h4
`define BSTP_OP_CLAMP 4'h5
`define BSTP_OP_BYPASS 4'hf

// ----------------------------------------------------------------------
// Shared pin positions
// ----------------------------------------------------------------------
`define BSTP_PIN_TCK 0
`define BSTP_PIN_TMS 1
`define BSTP_PIN_TDI 2
`define BSTP_PIN_TDO 3
`define BSTP_PIN_TRST 4

// ----------------------------------------------------------------------
// Identification code (value arbitrary, bit 0 set as required)
// ----------------------------------------------------------------------
`define BSTP_IDCODE_RST 32'h0a5c_3001

`endif

// file: bstp_cell.v
// One boundary-scan register bit with capture, shift and update stages
`timescale 1ns/100ps
module bstp_cell
(
   // Clock and resets
   input wire clk_sys,
   input wire nrst,
   input wire tap_rst,
   // Stage strobes, each one clock wide
   input wire capture_en,
   input wire shift_en,
   input wire update_en,
   // Data
   input wire cap_val,
   input wire ser_in,
   output reg ser_out,
   output reg upd_out
);

   // Shift stage
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         ser_out <= 1'b0;
      else if (capture_en)
         ser_out <= cap_val;
      else if (shift_en)
         ser_out <= ser_in;
   end

   // Update stage, cleared by test reset
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         upd_out <= 1'b0;
      else if (tap_rst)
         upd_out <= 1'b0;
      else if (update_en)
         upd_out <= ser_out;
   end

endmodule // bstp_cell

// file: bstp_top.v
// Boundary-scan test access port with shared GPIO pins and scan cells
`timescale 1ns/100ps
`include "bstp_regs.vh"
module bstp_top
#(
   parameter NUM_PINS = 8,
   parameter [31:0] IDCODE = `BSTP_IDCODE_RST
)
(
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Mode pin
   input wire test_select_n,
   // Shared pads, five GPIO pins
   input wire [4:0] gpio_pad_in,
   output reg [4:0] gpio_pad_out,
   output reg [4:0] gpio_pad_oe,
   // Core side of the shared GPIO pins
   input wire [4:0] core_gpio_out,
   input wire [4:0] core_gpio_oe,
   output reg [4:0] core_gpio_in,
   // Scanned device pins, pad side
   input wire [NUM_PINS-1:0] pin_in,
   output reg [NUM_PINS-1:0] pin_out,
   output reg [NUM_PINS-1:0] pin_oe,
   // Scanned device pins, core side
   input wire [NUM_PINS-1:0] core_pin_out,
   input wire [NUM_PINS-1:0] core_pin_oe,
   output reg [NUM_PINS-1:0] core_pin_in,
   // Device operational enable
   output reg core_run
);

   // ----------------------------------------------------------------------
   // TAP states
   // ----------------------------------------------------------------------
   localparam S_TLR = 4'h0, S_RTI = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
   localparam S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PAU_DR = 4'h6, S_EX2_DR = 4'h7;
   localparam S_UPD_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb;
   localparam S_EX1_IR = 4'hc, S_PAU_IR = 4'hd, S_EX2_IR = 4'he, S_UPD_IR = 4'hf;
   localparam NC = 2 * NUM_PINS;

   reg [4:0] pad_s1_r, pad_s2_r;
   reg [NUM_PINS-1:0] pin_s1_r, pin_s2_r;
   reg tsel_s1_r, tsel_s2_r, tck_d_r, bypass_r, tdo_r, tdo_en_r;
   reg [3:0] state_r, state_nxt;
   reg [`BSTP_IR_W-1:0] ir_sh_r, ir_r;
   reg [31:0] id_r;
   wire tck_rise, tck_fall, tap_rst, tms, tdi, dr_out;
   wire sel_bsc, sel_id, drive_bsc, hiz, cap_bsc, sh_bsc, upd_bsc;
   wire [NC-1:0] cap_vec, chain, upd_vec;

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // Two stages for every pad and the mode pin
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pad_s1_r <= 5'h00;
         pad_s2_r <= 5'h00;
         pin_s1_r <= {NUM_PINS{1'b0}};
         pin_s2_r <= {NUM_PINS{1'b0}};
         tsel_s1_r <= 1'b1;
         tsel_s2_r <= 1'b1;
         tck_d_r <= 1'b0;
      end
      else
      begin
         pad_s1_r <= gpio_pad_in;
         pad_s2_r <= pad_s1_r;
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         tsel_s1_r <= test_select_n;
         tsel_s2_r <= tsel_s1_r;
         tck_d_r <= pad_s2_r[`BSTP_PIN_TCK];
      end
   end

   // Test clock edges and serial inputs
   assign tck_rise = pad_s2_r[`BSTP_PIN_TCK] & ~tck_d_r;
   assign tck_fall = ~pad_s2_r[`BSTP_PIN_TCK] & tck_d_r;
   assign tms = pad_s2_r[`BSTP_PIN_TMS];
   assign tdi = pad_s2_r[`BSTP_PIN_TDI];
   // Port held in reset outside test mode or on test reset low
   assign tap_rst = tsel_s2_r | ~pad_s2_r[`BSTP_PIN_TRST];

   // ----------------------------------------------------------------------
   // TAP state machine
   // ----------------------------------------------------------------------
   // Next state from mode select
   always @*
   begin
      case (state_r)
         S_TLR: state_nxt = tms ? S_TLR : S_RTI;
         S_RTI: state_nxt = tms ? S_SEL_DR : S_RTI;
         S_SEL_DR: state_nxt = tms ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: state_nxt = tms ? S_EX1_DR : S_SH_DR;
         S_SH_DR: state_nxt = tms ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: state_nxt = tms ? S_UPD_DR : S_PAU_DR;
         S_PAU_DR: state_nxt = tms ? S_EX2_DR : S_PAU_DR;
         S_EX2_DR: state_nxt = tms ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: state_nxt = tms ? S_SEL_DR : S_RTI;
         S_SEL_IR: state_nxt = tms ? S_TLR : S_CAP_IR;
         S_CAP_IR: state_nxt = tms ? S_EX1_IR : S_SH_IR;
         S_SH_IR: state_nxt = tms ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: state_nxt = tms ? S_UPD_IR : S_PAU_IR;
         S_PAU_IR: state_nxt = tms ? S_EX2_IR : S_PAU_IR;
         S_EX2_IR: state_nxt = tms ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: state_nxt = tms ? S_SEL_DR : S_RTI;
         default: state_nxt = S_TLR;
      endcase
   end

   // State register, advances on test clock rise
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         state_r <= S_TLR;
      else if (tap_rst)
         state_r <= S_TLR;
      else if (tck_rise)
         state_r <= state_nxt;
   end

   // ----------------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------------
   // Capture and shift on rise, update on fall
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ir_sh_r <= `BSTP_IR_CAPTURE;
         ir_r <= `BSTP_OP_IDCODE;
      end
      else if (tap_rst || state_r == S_TLR)
      begin
         ir_sh_r <= `BSTP_IR_CAPTURE;
         ir_r <= `BSTP_OP_IDCODE;
      end
      else
      begin
         if (tck_rise && state_r == S_CAP_IR)
            ir_sh_r <= `BSTP_IR_CAPTURE;
         else if (tck_rise && state_r == S_SH_IR)
            ir_sh_r <= {tdi, ir_sh_r[`BSTP_IR_W-1:1]};
         if (tck_fall && state_r == S_UPD_IR)
            ir_r <= ir_sh_r;
      end
   end

   // Instruction decode, unknown codes act as bypass
   assign sel_bsc = (ir_r == `BSTP_OP_EXTEST) | (ir_r == `BSTP_OP_SAMPLE) |
                    (ir_r == `BSTP_OP_PRELOAD);
   assign sel_id = (ir_r == `BSTP_OP_IDCODE);
   assign drive_bsc = (ir_r == `BSTP_OP_EXTEST) | (ir_r == `BSTP_OP_CLAMP);
   assign hiz = (ir_r == `BSTP_OP_HIGHZ);

   // ----------------------------------------------------------------------
   // Identification and bypass registers
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         id_r <= 32'h0000_0000;
         bypass_r <= 1'b0;
      end
      else if (tck_rise && state_r == S_CAP_DR)
      begin
         id_r <= IDCODE;
         bypass_r <= 1'b0;
      end
      else if (tck_rise && state_r == S_SH_DR)
      begin
         id_r <= {tdi, id_r[31:1]};
         bypass_r <= tdi;
      end
   end

   // ----------------------------------------------------------------------
   // Boundary-scan cells: even index is enable, odd is data
   // ----------------------------------------------------------------------
   assign cap_bsc = tck_rise & (state_r == S_CAP_DR) & sel_bsc;
   assign sh_bsc = tck_rise & (state_r == S_SH_DR) & sel_bsc;
   assign upd_bsc = tck_fall & (state_r == S_UPD_DR) & sel_bsc;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1)
      begin : g_cap
         assign cap_vec[2*gi] = core_pin_oe[gi];
         assign cap_vec[2*gi+1] = pin_s2_r[gi];
      end
      for (gi = 0; gi < NC; gi = gi + 1)
      begin : g_cell
         bstp_cell u_cell
         (
            .clk_sys(clk_sys), .nrst(nrst), .tap_rst(tap_rst),
            .capture_en(cap_bsc), .shift_en(sh_bsc), .update_en(upd_bsc),
            .cap_val(cap_vec[gi]), .ser_in((gi == NC - 1) ? tdi : chain[(gi + 1) % NC]),
            .ser_out(chain[gi]), .upd_out(upd_vec[gi])
         );
      end
   endgenerate

   // Serial output select for the data path
   assign dr_out = sel_id ? id_r[0] :
                   (sel_bsc ? chain[0] : bypass_r);

   // Test data out changes on test clock fall, driven only while shifting
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         tdo_r <= 1'b0;
         tdo_en_r <= 1'b0;
      end
      else if (tap_rst)
      begin
         tdo_r <= 1'b0;
         tdo_en_r <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_r <= (state_r == S_SH_IR) ? ir_sh_r[0] : dr_out;
         tdo_en_r <= (state_r == S_SH_IR) | (state_r == S_SH_DR);
      end
   end

   // ----------------------------------------------------------------------
   // Pad and core multiplexing
   // ----------------------------------------------------------------------
   // Shared GPIO pins, test roles while test-select is low
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         gpio_pad_out <= 5'h00;
         gpio_pad_oe <= 5'h00;
         core_gpio_in <= 5'h00;
         core_run <= 1'b0;
      end
      else if (!tsel_s2_r)
      begin
         gpio_pad_out <= 5'h00;
         gpio_pad_out[`BSTP_PIN_TDO] <= tdo_r;
         gpio_pad_oe <= 5'h00;
         gpio_pad_oe[`BSTP_PIN_TDO] <= tdo_en_r;
         core_gpio_in <= 5'h00;
         core_run <= 1'b0;
      end
      else
      begin
         gpio_pad_out <= core_gpio_out;
         gpio_pad_oe <= core_gpio_oe;
         core_gpio_in <= pad_s2_r;
         core_run <= 1'b1;
      end
   end

   // Scanned pins: cells drive on EXTEST or CLAMP, HIGHZ floats them
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1)
      begin : g_pin
         always @(posedge clk_sys or negedge nrst)
         begin
            if (!nrst)
            begin
               pin_out[gi] <= 1'b0;
               pin_oe[gi] <= 1'b0;
               core_pin_in[gi] <= 1'b0;
            end
            else if (!tsel_s2_r && (drive_bsc || hiz))
            begin
               pin_out[gi] <= upd_vec[2*gi+1] & ~hiz;
               pin_oe[gi] <= upd_vec[2*gi] & ~hiz;
               core_pin_in[gi] <= 1'b0;
            end
            else
            begin
               pin_out[gi] <= core_pin_out[gi];
               pin_oe[gi] <= core_pin_oe[gi];
               core_pin_in[gi] <= tsel_s2_r & pin_s2_r[gi];
            end
         end
      end
   endgenerate

endmodule // bstp_top

// file: bstp_top_monitor.sv
// Assertion checker for the boundary-scan test port
`timescale 1ns/100ps
module bstp_mon
#(
   parameter NUM_PINS = 8
)
(
   // Clock, reset, mode
   input wire clk_sys,
   input wire nrst,
   input wire test_select_n,
   // Shared pads
   input wire [4:0] gpio_pad_in,
   input wire [4:0] gpio_pad_out,
   input wire [4:0] gpio_pad_oe,
   input wire [4:0] core_gpio_out,
   input wire [4:0] core_gpio_oe,
   input wire [4:0] core_gpio_in,
   // Scanned pins
   input wire [NUM_PINS-1:0] pin_in,
   input wire [NUM_PINS-1:0] pin_out,
   input wire [NUM_PINS-1:0] pin_oe,
   input wire [NUM_PINS-1:0] core_pin_out,
   input wire [NUM_PINS-1:0] core_pin_oe,
   input wire [NUM_PINS-1:0] core_pin_in,
   input wire core_run
);
   // -------------------------------------------------------------
   // Mode and pad properties
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   AST_RUN_OFF: assert property ((!test_select_n)[*4] |-> !core_run)
      else $error("core runs in test mode");
   AST_RUN_ON: assert property (test_select_n[*5] |-> core_run)
      else $error("core idle in normal mode");
   AST_RUN_CAUSE: assert property ($rose(core_run) |-> $past(test_select_n, 2))
      else $error("core started without mode release");
   AST_TEST_PADS: assert property ((!test_select_n)[*4] |-> (gpio_pad_out & 5'h17) == 5'h00
      && (gpio_pad_oe & 5'h17) == 5'h00 && core_gpio_in == 5'h00 && core_pin_in == '0)
      else $error("shared pads not in test role");
   AST_NORM_PADS: assert property ((test_select_n && $stable(core_gpio_out)
      && $stable(core_gpio_oe))[*5] |-> gpio_pad_out == core_gpio_out
      && gpio_pad_oe == core_gpio_oe)
      else $error("pads not following core");
   AST_NORM_PINS: assert property ((test_select_n && $stable(core_pin_out)
      && $stable(core_pin_oe))[*5] |-> pin_out == core_pin_out && pin_oe == core_pin_oe)
      else $error("pins not following core");
   AST_IN_NORM: assert property ((test_select_n && $stable(pin_in) && $stable(gpio_pad_in))[*5]
      |-> core_pin_in == pin_in && core_gpio_in == gpio_pad_in)
      else $error("inputs not passed to core");
   AST_TRST: assert property ((!test_select_n && !gpio_pad_in[4] && $stable(core_pin_out)
      && $stable(core_pin_oe))[*5] |-> pin_out == core_pin_out
      && pin_oe == core_pin_oe && gpio_pad_oe == 5'h00)
      else $error("test reset not holding port idle");
endmodule // bstp_mon

// file: bstp_host.sv
// Model of the outside boundary-scan controller
`timescale 1ns/100ps
module bstp_host
(
   // Link pins
   output reg tck,
   output reg tms,
   output reg tdi,
   output reg trst_n,
   input wire tdo
);
   // Clock parked low between frames
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b1;
   end
   // One 200 ns test clock; data out read just before the fall
   task tick(input logic m, input logic d, output logic o);
   begin
      tms = m;
      tdi = d;
      #100;
      tck = 1'b1;
      #99;
      o = tdo;
      #1;
      tck = 1'b0;
   end
   endtask
   // Idle, walk to a shift state, shift n bits LSB first, update, idle
   task scan(input logic ir, input int n, input logic [31:0] di, output logic [31:0] dq);
      logic b;
      int i;
   begin
      dq = 32'h0;
      #7;
      tick(1'b0, 1'b0, b);
      tick(1'b1, 1'b0, b);
      if (ir)
         tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (i = 0; i < n; i++)
      begin
         tick(i == n - 1, di[i], b);
         dq[i] = b;
      end
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   end
   endtask
endmodule // bstp_host

// file: bstp_top_tb_top.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module bstp_top_tb_top;
   localparam [31:0] IDV = 32'h1357_9bdf; // Arbitrary identification value
   logic clk_sys, nrst, test_select_n, tdo_last;
   logic [4:0] gpio_r, core_gpio_out, core_gpio_oe;
   logic [7:0] pin_in, core_pin_out, core_pin_oe, po, pe;
   wire [4:0] gpio_pad_in, gpio_pad_out, gpio_pad_oe, core_gpio_in;
   wire [7:0] pin_out, pin_oe, core_pin_in;
   wire core_run, tck, tms, tdi, trst_n, tdo_w;
   logic [31:0] exp_q[$];
   logic [31:0] got, e, di, dq, x;
   logic [15:0] cap;
   logic [3:0] ops [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h5, 4'h4, 4'hf, 4'h7};
   int errors, num_checks, i, k;
   event got_ev;
   // Pad wire: released data out shows the inverse of its last level
   assign tdo_w = gpio_pad_oe[3] ? gpio_pad_out[3] : ~tdo_last;
   assign gpio_pad_in = test_select_n ? gpio_r : {trst_n, tdo_w, tdi, tms, tck};
   always @(posedge clk_sys)
      if (gpio_pad_oe[3])
         tdo_last <= gpio_pad_out[3];
   bstp_top #(.NUM_PINS(8), .IDCODE(IDV)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
      .test_select_n(test_select_n), .gpio_pad_in(gpio_pad_in), .gpio_pad_out(gpio_pad_out),
      .gpio_pad_oe(gpio_pad_oe), .core_gpio_out(core_gpio_out), .core_gpio_oe(core_gpio_oe),
      .core_gpio_in(core_gpio_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe), .core_pin_in(core_pin_in),
      .core_run(core_run));
   bstp_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_w));
   // -------------------------------------------------------------
   // Clock, checking and closing
   // -------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Oldest expectation against each result
   always @(got_ev)
   begin
      e = exp_q.pop_front();
      num_checks++;
      if (got !== e)
      begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, got);
      end
   end
   task chk(input logic [31:0] ex, input logic [31:0] g);
   begin
      exp_q.push_back(ex);
      got = g;
      ->got_ev;
      #1;
   end
   endtask
   task summarize;
   begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // Hang guard
   initial
   begin
      #1000000;
      errors++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {nrst, test_select_n, tdo_last, gpio_r, core_gpio_out, core_gpio_oe} = 18'h18000;
      {pin_in, core_pin_out, core_pin_oe, po, pe} = 40'h0;
      errors = 0;
      num_checks = 0;
      x = $urandom(32'ha9c06b16);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         x = $urandom;
         @(posedge clk_sys);
         {pin_in, core_pin_out, core_pin_oe} <= {x[23:0]};
         {gpio_r, core_gpio_out, core_gpio_oe} <= x[31:17];
         repeat (6) @(posedge clk_sys);
         #1;
         chk(32'(core_gpio_out), 32'(gpio_pad_out));
         chk(32'(gpio_r), 32'(core_gpio_in));
         chk(32'({core_pin_out, core_pin_oe}), 32'({pin_out, pin_oe}));
         chk(32'h1, 32'(core_run));
      end
      $display("test normal done");
      @(posedge clk_sys);
      test_select_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      chk(32'h0, 32'({core_run, core_gpio_in, core_pin_in}));
      for (k = 0; k < 8; k++)
         cap[2*k+:2] = {pin_in[k], core_pin_oe[k]};
      u_host.scan(1'b0, 32, 32'h0, dq);
      chk(IDV, dq);
      $display("test ident done");
      for (i = 0; i < 8; i++)
      begin
         u_host.scan(1'b1, 4, 32'(ops[i]), dq);
         chk(32'h1, dq);
         di = $urandom;
         u_host.scan(1'b0, 32, di, dq);
         x = ops[i] == 4'h3 ? IDV : ops[i] < 4'h3 ? {di[15:0], cap} : {di[30:0], 1'b0};
         chk(x, dq);
         case (ops[i])
            4'h0: for (k = 0; k < 8; k++) {po[k], pe[k]} = di[17+2*k-:2];
            4'h4: {po, pe} = 16'h0;
            4'h5: ;
            default: {po, pe} = {core_pin_out, core_pin_oe};
         endcase
         chk(32'({po, pe}), 32'({pin_out, pin_oe}));
      end
      $display("test opcodes done");
      @(posedge clk_sys);
      u_host.trst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(32'({core_pin_out, core_pin_oe, 5'h00}), 32'({pin_out, pin_oe, gpio_pad_oe}));
      @(posedge clk_sys);
      u_host.trst_n <= 1'b1;
      u_host.scan(1'b0, 32, 32'h0, dq);
      chk(IDV, dq);
      $display("test trst done");
      @(posedge clk_sys);
      test_select_n <= 1'b1;
      nrst <= 1'b0;
      @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      chk(32'({1'b1, core_gpio_out}), 32'({core_run, gpio_pad_out}));
      $display("test release done");
      summarize();
   end
endmodule // bstp_top_tb_top
bind bstp_top bstp_mon #(.NUM_PINS(NUM_PINS)) u_mon (.clk_sys(clk_sys), .nrst(nrst),
   .test_select_n(test_select_n), .gpio_pad_in(gpio_pad_in), .gpio_pad_out(gpio_pad_out),
   .gpio_pad_oe(gpio_pad_oe), .core_gpio_out(core_gpio_out), .core_gpio_oe(core_gpio_oe),
   .core_gpio_in(core_gpio_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe), .core_pin_in(core_pin_in),
   .core_run(core_run));
